// >>> design/emx_exec.v
// execution unit for the accumulator/memory exchange instructions with x xor and y step
`timescale 1ns/1ps
`include "emx_exec_regs.vh"

module emx_exec (
    input wire clk_sys,
    input wire rst,
    // decoded instruction request
    input wire op_valid,
    input wire op_incr,
    input wire [3:0] op_imm,
    output wire op_ready,
    // completion
    output reg op_done_ff,
    output reg skip_next_ff,
    // register load port for other instructions
    input wire load_en,
    input wire [1:0] load_sel,
    input wire [3:0] load_data,
    // register view
    output reg [3:0] acc_ff,
    output reg [3:0] reg_x_ff,
    output reg [3:0] reg_y_ff,
    // ram port
    output wire [7:0] ram_nibble_pointer,
    input wire [3:0] ram_rd_data,
    output reg ram_wr_en_ff,
    output reg [3:0] ram_wr_data_ff
);

    // ----------------------------------------------------------------
    // execution states
    // ----------------------------------------------------------------
    localparam [1:0] ST_IDLE = `EMX_ST_IDLE;
    localparam [1:0] ST_READ = `EMX_ST_READ;
    localparam [1:0] ST_WRITE = `EMX_ST_WRITE;

    // ----------------------------------------------------------------
    // state and latched operands
    // ----------------------------------------------------------------
    reg [1:0] state_ff;
    reg [1:0] nxt_state;
    reg incr_ff;
    reg [3:0] imm_ff;
    reg [3:0] mem_ff;
    wire [3:0] y_stepped;
    wire skip_hit;
    reg nxt_done;
    reg nxt_skip;
    reg [3:0] nxt_acc;
    reg [3:0] nxt_x;
    reg [3:0] nxt_y;

    // ----------------------------------------------------------------
    // decode of the load port select, used for all three registers
    // ----------------------------------------------------------------
    function load_hit;
        input en;
        input [1:0] sel;
        input [1:0] code;
        begin
            load_hit = en && (sel == code);
        end
    endfunction

    // the pointer is formed from x and y and stays put until the write is done
    assign ram_nibble_pointer = {reg_x_ff, reg_y_ff};

    // a new instruction is taken only when idle
    assign op_ready = (state_ff == ST_IDLE);

    // y step and skip decision
    emx_step u_step (
        .y_old(reg_y_ff),
        .incr(incr_ff),
        .y_new(y_stepped),
        .skip(skip_hit)
    );

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (op_valid) begin
                    nxt_state = ST_READ;
                end
            end
            ST_READ: begin
                nxt_state = ST_WRITE;
            end
            ST_WRITE: begin
                nxt_state = ST_IDLE;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // sequencing: latch operands, read ram, then write the old accumulator back
    // ----------------------------------------------------------------
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_ff <= ST_IDLE;
            incr_ff <= 1'b0;
            imm_ff <= 4'h0;
            mem_ff <= 4'h0;
            ram_wr_en_ff <= 1'b0;
            ram_wr_data_ff <= 4'h0;
        end else begin
            state_ff <= nxt_state;
            ram_wr_en_ff <= 1'b0;
            case (state_ff)
                ST_IDLE: begin
                    if (op_valid) begin
                        incr_ff <= op_incr;
                        imm_ff <= op_imm;
                    end
                end
                ST_READ: begin
                    // old memory nibble captured, old accumulator goes out to ram
                    mem_ff <= ram_rd_data;
                    ram_wr_data_ff <= acc_ff;
                    ram_wr_en_ff <= 1'b1;
                end
                ST_WRITE: begin
                    // operands stay put until the register update has used them
                    imm_ff <= imm_ff;
                end
                default: begin
                    incr_ff <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // completion pulses: one cycle each, on the edge that updates a, x and y
    // ----------------------------------------------------------------
    always @* begin
        nxt_done = 1'b0;
        nxt_skip = 1'b0;
        if (state_ff == ST_WRITE) begin
            nxt_done = 1'b1;
            nxt_skip = skip_hit;
        end
    end

    // pulse registers, cleared by reset so no false skip follows it
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            op_done_ff <= 1'b0;
            skip_next_ff <= 1'b0;
        end else begin
            op_done_ff <= nxt_done;
            skip_next_ff <= nxt_skip;
        end
    end

    // ----------------------------------------------------------------
    // accumulator, x and y: load port when idle, exchange results at write end
    // ----------------------------------------------------------------
    always @* begin
        nxt_acc = acc_ff;
        nxt_x = reg_x_ff;
        nxt_y = reg_y_ff;
        case (state_ff)
            ST_WRITE: begin
                nxt_acc = mem_ff;
                nxt_x = reg_x_ff ^ imm_ff;
                nxt_y = y_stepped;
            end
            ST_IDLE: begin
                if (load_hit(load_en, load_sel, `EMX_SEL_ACC)) begin
                    nxt_acc = load_data;
                end
                if (load_hit(load_en, load_sel, `EMX_SEL_X)) begin
                    nxt_x = load_data;
                end
                if (load_hit(load_en, load_sel, `EMX_SEL_Y)) begin
                    nxt_y = load_data;
                end
            end
            default: begin
                // the load port is shut while an exchange is in flight
                nxt_acc = acc_ff;
            end
        endcase
    end

    // register view of a, x and y
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            acc_ff <= `EMX_ACC_RST;
            reg_x_ff <= `EMX_X_RST;
            reg_y_ff <= `EMX_Y_RST;
        end else begin
            acc_ff <= nxt_acc;
            reg_x_ff <= nxt_x;
            reg_y_ff <= nxt_y;
        end
    end

endmodule

// >>> design/emx_exec_regs.vh
// constants for the exchange-memory / index-step execution unit
`ifndef EMX_EXEC_REGS_VH
`define EMX_EXEC_REGS_VH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define EMX_NIB_W 4
`define EMX_PTR_W 8

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define EMX_ACC_RST 4'h0
`define EMX_X_RST 4'h0
`define EMX_Y_RST 4'h0

// ----------------------------------------------------------------
// wrap values of y that make the next instruction skip, and the y step size
// ----------------------------------------------------------------
`define EMX_DEC_SKIP_VAL 4'hf
`define EMX_INC_SKIP_VAL 4'h0
`define EMX_Y_STEP 4'h1

// ----------------------------------------------------------------
// register select codes on the load port
// ----------------------------------------------------------------
`define EMX_SEL_ACC 2'h0
`define EMX_SEL_X 2'h1
`define EMX_SEL_Y 2'h2

// ----------------------------------------------------------------
// execution state codes
// ----------------------------------------------------------------
`define EMX_ST_IDLE 2'h0
`define EMX_ST_READ 2'h1
`define EMX_ST_WRITE 2'h2

`endif

// >>> design/emx_step.v
// y stepping and skip decision for the exchange instructions
`timescale 1ns/1ps
`include "emx_exec_regs.vh"

module emx_step (
    input wire [3:0] y_old,
    input wire incr,
    output wire [3:0] y_new,
    output wire skip
);

    // ----------------------------------------------------------------
    // step y modulo 16 and test the wrap value on the new y
    // ----------------------------------------------------------------
    assign y_new = incr ? (y_old + `EMX_Y_STEP) : (y_old - `EMX_Y_STEP);
    // skip is judged on the updated value
    assign skip = incr ? (y_new == `EMX_INC_SKIP_VAL) : (y_new == `EMX_DEC_SKIP_VAL);

endmodule

// >>> test/emx_exec_sva.sv
// assertion checker for the exchange execution unit
`timescale 1ns/1ps
module emx_exec_sva (
    input wire clk_sys, rst, op_valid, op_incr, op_ready, op_done_ff, skip_next_ff, load_en, ram_wr_en_ff,
    input wire [1:0] load_sel,
    input wire [3:0] op_imm, load_data, acc_ff, reg_x_ff, reg_y_ff, ram_rd_data, ram_wr_data_ff,
    input wire [7:0] ram_nibble_pointer
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // a request is taken on an idle edge
    wire take = op_valid && op_ready;
    chk_done_lat: assert property (take |-> ##3 op_done_ff) else $error("late done");
    chk_busy_win: assert property (take |=> !op_ready [*2] ##1 op_ready) else $error("busy window");
    chk_wr_old: assert property (take |-> ##2 ram_wr_en_ff && ram_wr_data_ff == $past(acc_ff, 2))
        else $error("bad ram write");
    chk_acc_swap: assert property (ram_wr_en_ff |=> acc_ff == $past(ram_rd_data)) else $error("acc swap");
    chk_x_xor: assert property (take |-> ##3 reg_x_ff == ($past(reg_x_ff, 3) ^ $past(op_imm, 3)))
        else $error("x xor");
    chk_y_dec: assert property (take && !op_incr |-> ##3 reg_y_ff == $past(reg_y_ff, 3) - 4'h1)
        else $error("y dec");
    chk_y_inc: assert property (take && op_incr |-> ##3 reg_y_ff == $past(reg_y_ff, 3) + 4'h1)
        else $error("y inc");
    chk_skip_dec: assert property (take && !op_incr |-> ##3 skip_next_ff == (reg_y_ff == 4'hf))
        else $error("dec skip");
    chk_skip_inc: assert property (take && op_incr |-> ##3 skip_next_ff == (reg_y_ff == 4'h0))
        else $error("inc skip");
    cover property (take && op_incr ##3 skip_next_ff);
    cover property (take && !op_incr ##3 skip_next_ff);
    cover property (load_en && !op_ready);
endmodule

// >>> test/emx_exec_tb.sv
// self-checking bench for the exchange execution unit
`timescale 1ns/1ps
module emx_exec_tb;
    logic clk_sys = 1'h0, rst = 1'h1, op_valid = 1'h0, op_incr = 1'h0, load_en = 1'h0;
    logic op_ready, op_done_ff, skip_next_ff, ram_wr_en_ff;
    logic [1:0] load_sel = 2'h0;
    logic [3:0] op_imm = 4'h0, load_data = 4'h0, acc_ff, reg_x_ff, reg_y_ff, ram_rd_data, ram_wr_data_ff;
    logic [3:0] ea, ex, ey, oa, mem [256];
    logic [3:0] cy [4] = '{4'h0, 4'h1, 4'hf, 4'he};
    logic [3:0] cj [4] = '{4'hf, 4'h0, 4'ha, 4'h5};
    logic [7:0] ram_nibble_pointer, op;
    logic [31:0] seed = 32'h34, r;
    int errors = 0, checks = 0;
    emx_exec u_emx_exec (
        .clk_sys(clk_sys),
        .rst(rst),
        .op_valid(op_valid),
        .op_incr(op_incr),
        .op_imm(op_imm),
        .op_ready(op_ready),
        .op_done_ff(op_done_ff),
        .skip_next_ff(skip_next_ff),
        .load_en(load_en),
        .load_sel(load_sel),
        .load_data(load_data),
        .acc_ff(acc_ff),
        .reg_x_ff(reg_x_ff),
        .reg_y_ff(reg_y_ff),
        .ram_nibble_pointer(ram_nibble_pointer),
        .ram_rd_data(ram_rd_data),
        .ram_wr_en_ff(ram_wr_en_ff),
        .ram_wr_data_ff(ram_wr_data_ff)
    );
    // ram: combinational read, write on the edge after the strobe
    assign ram_rd_data = mem[ram_nibble_pointer];
    always @(posedge clk_sys) if (ram_wr_en_ff) mem[ram_nibble_pointer] <= ram_wr_data_ff;
    initial forever #5 clk_sys = ~clk_sys;
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task cmp(string n, logic [3:0] e, logic [3:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task end_sim();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task view();
        cmp("acc", ea, acc_ff);
        cmp("x", ex, reg_x_ff);
        cmp("y", ey, reg_y_ff);
    endtask
    task load(logic [1:0] s, logic [3:0] d);
        @(posedge clk_sys);
        load_en <= 1'h1;
        load_sel <= s;
        load_data <= d;
        @(posedge clk_sys);
        load_en <= 1'h0;
        #1;
        if (s == 2'h0) ea = d;
        else if (s == 2'h1) ex = d;
        else ey = d;
        view();
    endtask
    // one exchange; lb pokes the load port while busy, which must be ignored
    task run(logic inc, logic [3:0] j, logic lb);
        int i;
        @(posedge clk_sys);
        op_valid <= 1'h1;
        op_incr <= inc;
        op_imm <= j;
        @(posedge clk_sys);
        op_valid <= 1'h0;
        load_en <= lb;
        load_sel <= 2'h0;
        load_data <= ~ea;
        op = {ex, ey};
        oa = ea;
        ea = mem[op];
        ex = ex ^ j;
        ey = inc ? ey + 4'h1 : ey - 4'h1;
        @(posedge clk_sys);
        load_en <= 1'h0;
        for (i = 0; i < 8 && op_done_ff !== 1'h1; i++) begin
            @(posedge clk_sys);
            #1;
        end
        if (i > 2) begin
            errors++;
            end_sim();
        end
        view();
        cmp("skip", {3'h0, inc ? ey == 4'h0 : ey == 4'hf}, {3'h0, skip_next_ff});
        cmp("mem", oa, mem[op]);
    endtask
    initial begin
        for (int k = 0; k < 256; k++) mem[k] = 4'(rnd());
        {ea, ex, ey} = 12'h0;
        repeat (10) @(posedge clk_sys);
        view();
        rst <= 1'h0;
        for (int k = 0; k < 4; k++) begin
            load(2'h2, cy[k]);
            run(k[1], cj[k], k[0]);
        end
        $display("corner test done");
        for (int k = 0; k < 40; k++) begin
            r = rnd();
            load(2'h0, r[3:0]);
            load(2'h1, r[7:4]);
            load(2'h2, r[11:8]);
            run(r[12], r[19:16], r[13]);
        end
        $display("random test done");
        end_sim();
    end
endmodule
bind emx_exec emx_exec_sva u_emx_exec_sva (
    .clk_sys(clk_sys),
    .rst(rst),
    .op_valid(op_valid),
    .op_incr(op_incr),
    .op_ready(op_ready),
    .op_done_ff(op_done_ff),
    .skip_next_ff(skip_next_ff),
    .load_en(load_en),
    .ram_wr_en_ff(ram_wr_en_ff),
    .load_sel(load_sel),
    .op_imm(op_imm),
    .load_data(load_data),
    .acc_ff(acc_ff),
    .reg_x_ff(reg_x_ff),
    .reg_y_ff(reg_y_ff),
    .ram_rd_data(ram_rd_data),
    .ram_wr_data_ff(ram_wr_data_ff),
    .ram_nibble_pointer(ram_nibble_pointer)
);
